// [hw/rwpsc_pkg.sv]
package rwpsc_pkg;
   // Device word indices on the link
   localparam logic [7:0] BUS_MODE_IDX = 8'h00;
   localparam logic [7:0] CFG18_IDX = 8'h12;
   localparam logic [7:0] PM_IDX = 8'h14;
   localparam logic [7:0] PHY_CTRL_IDX = 8'h28;
   // Field positions
   localparam int SOFT_RST_BIT = 0;
   localparam int PHY_RST_BIT = 15;
   localparam int WAKE_EN_BIT = 18;
   localparam int PME_STAT_BIT = 15;
   localparam int PSTATE_LSB = 0;
   localparam int RECALL_LSB = 16;
   // Reset values
   localparam logic [31:0] BUS_MODE_RST = 32'h0000_0000;
   localparam logic [31:0] CFG18_RST = 32'h0000_0000;
   localparam logic [15:0] PHY_CTRL_RST = 16'h0000;
   // Wake pattern and EEPROM recall
   localparam logic [7:0] WAKE_SYNC_BYTE = 8'hFF;
   localparam logic [2:0] WAKE_FF_MIN = 3'h6;
   localparam logic [3:0] WAKE_LAST_REP = 4'hF;
   localparam logic [2:0] MAC_LAST_BYTE = 3'h5;
   localparam logic [6:0] EE_RECALL_OFS = 7'h2E;
   // Power and bus states
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D1 = 2'h1;
   localparam logic [1:0] PS_D2 = 2'h2;
   localparam logic [1:0] PS_D3 = 2'h3;
   localparam logic [1:0] BS_B0 = 2'h0;
   localparam logic [1:0] BS_B1 = 2'h1;
   // Timing
   localparam longint CLK_HZ = 64'd40000000;
   localparam longint MIN_PCLK_HZ = 64'd16000000;
   localparam longint HRST_MS = 64'd100;
   localparam longint HRST_CYCLES = (HRST_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam logic [3:0] SRST_CYCLES = 4'h8;
   localparam logic [3:0] PHY_RST_CYCLES = 4'h8;
   localparam logic [4:0] TIMEOUT_CYCLES = 5'h10;
   // Host APB map and fields
   localparam logic [7:0] H_CTRL = 8'h00;
   localparam logic [7:0] H_ADDR = 8'h04;
   localparam logic [7:0] H_WDATA = 8'h08;
   localparam logic [7:0] H_RDATA = 8'h0C;
   localparam logic [7:0] H_STATUS = 8'h10;
   localparam int C_GO = 0;
   localparam int C_WRITE = 1;
   localparam int C_CFG = 2;
   localparam int C_HRST = 3;
   localparam int C_BS_LSB = 8;
   localparam int S_BUSY = 0;
   localparam int S_DONE = 1;
   localparam int S_ABORT = 2;
   localparam int S_PME = 3;
   localparam int S_RST = 4;
   localparam int S_REINIT = 5;
endpackage

// [hw/rwpsc_link_if.sv]
interface rwpsc_link_if (
   input wire logic pclk
);
   logic pci_rst_n;
   logic [1:0] bus_state;
   logic req;
   logic req_cfg;
   logic req_we;
   logic [7:0] req_addr;
   logic [31:0] req_wdata;
   logic ack;
   logic [31:0] rdata;
   logic pme_o;
   logic pme_oe_n;
   logic pme_n;

   // Open drain with pull-up
   assign pme_n = pme_oe_n ? 1'b1 : pme_o;

   modport dev (
      input pci_rst_n, bus_state, req, req_cfg, req_we, req_addr, req_wdata,
      output ack, rdata, pme_o, pme_oe_n
   );
   modport host (
      output pci_rst_n, bus_state, req, req_cfg, req_we, req_addr, req_wdata,
      input ack, rdata, pme_n
   );
endinterface

// [hw/rwpsc_dev.sv]
// The register offsets and the APB slave port were decided locally.
module rwpsc_dev (
   input wire logic pclk,
   input wire logic presetn,
   rwpsc_link_if.dev link,
   input wire logic [47:0] station_addr,
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic rx_eof,
   input wire logic [7:0] rx_data,
   input wire logic rx_addr_ok,
   input wire logic rx_crc_ok,
   input wire logic ee_valid,
   input wire logic [15:0] ee_data,
   output logic ee_load_req,
   output logic [6:0] ee_addr,
   output logic mac_enable,
   output logic chip_reset,
   output logic phy_reset,
   output logic wake_event,
   output logic [1:0] power_state
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0] bus_mode;
      logic [31:0] cfg18;
      logic [15:0] phy_ctrl;
      logic [1:0] pstate;
      logic pme_stat;
      logic pme_oe_n;
      logic pme_o;
      logic ack;
      logic [31:0] rdata;
      logic in_reset;
      logic [3:0] rst_cnt;
      logic phy_rst;
      logic [3:0] phy_cnt;
      logic loading;
      logic [6:0] ee_addr;
      logic [2:0] ff_cnt;
      logic in_match;
      logic [2:0] byte_idx;
      logic [3:0] rep;
      logic found;
      logic wake;
      logic mac_en;
   } rwpsc_dev_st_t;

   // Power-up condition; every reset path except the transceiver reset starts from it
   localparam rwpsc_dev_st_t DEV_RST = '{
      bus_mode: rwpsc_pkg::BUS_MODE_RST,
      cfg18: rwpsc_pkg::CFG18_RST,
      phy_ctrl: rwpsc_pkg::PHY_CTRL_RST,
      pstate: rwpsc_pkg::PS_D0,
      pme_oe_n: 1'b1,
      in_reset: 1'b1,
      rst_cnt: rwpsc_pkg::SRST_CYCLES,
      ee_addr: rwpsc_pkg::EE_RECALL_OFS,
      default: '0
   };

   rwpsc_dev_st_t s;
   rwpsc_dev_st_t next_s;
   logic [7:0] mac_byte;
   logic [31:0] pm_word;
   logic [31:0] rd_word;
   logic take;
   logic cfg_ok;
   logic io_ok;
   logic do_reset;
   logic hit;
   logic done_now;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      mac_byte = 8'h00;
      for (int k = 0; k < 6; k++) begin
         if (s.byte_idx == 3'(k)) begin
            mac_byte = station_addr[8 * (5 - k) +: 8];
         end
      end
   end

   always_comb begin
      pm_word = 32'h0000_0000;
      pm_word[rwpsc_pkg::PME_STAT_BIT] = s.pme_stat;
      pm_word[rwpsc_pkg::PSTATE_LSB +: 2] = s.pstate;
      rd_word = 32'h0000_0000;
      if (link.req_cfg) begin
         if (link.req_addr == rwpsc_pkg::PM_IDX) begin
            rd_word = pm_word;
         end
      end else begin
         unique case (link.req_addr)
            rwpsc_pkg::BUS_MODE_IDX: rd_word = s.bus_mode;
            rwpsc_pkg::CFG18_IDX: rd_word = s.cfg18;
            rwpsc_pkg::PM_IDX: rd_word = pm_word;
            rwpsc_pkg::PHY_CTRL_IDX: rd_word = {16'h0000, s.phy_ctrl};
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.wake = 1'b0;
      do_reset = 1'b0;
      hit = 1'b0;
      done_now = 1'b0;

      // Config space stays reachable in D3hot while clocked
      cfg_ok = link.req_cfg && ((s.pstate == rwpsc_pkg::PS_D0) || (s.pstate == rwpsc_pkg::PS_D1)
               || (link.bus_state == rwpsc_pkg::BS_B0) || (link.bus_state == rwpsc_pkg::BS_B1));
      io_ok = !link.req_cfg && (s.pstate == rwpsc_pkg::PS_D0);
      // No answer at all: the host sees a master abort
      take = link.req && !s.ack && !s.in_reset && (cfg_ok || io_ok);

      if (take) begin
         next_s.ack = 1'b1;
         next_s.rdata = rd_word;
         if (link.req_we) begin
            if (link.req_addr == rwpsc_pkg::PM_IDX) begin
               next_s.pstate = link.req_wdata[rwpsc_pkg::PSTATE_LSB +: 2];
               if (link.req_wdata[rwpsc_pkg::PME_STAT_BIT]) begin
                  next_s.pme_stat = 1'b0;
               end
               if (s.pstate == rwpsc_pkg::PS_D3 && link.req_wdata[rwpsc_pkg::PSTATE_LSB +: 2] == rwpsc_pkg::PS_D0) begin
                  do_reset = 1'b1;
               end
            end else if (!link.req_cfg) begin
               unique case (link.req_addr)
                  rwpsc_pkg::BUS_MODE_IDX: begin
                     next_s.bus_mode = link.req_wdata;
                     do_reset = link.req_wdata[rwpsc_pkg::SOFT_RST_BIT];
                  end
                  rwpsc_pkg::CFG18_IDX: next_s.cfg18 = link.req_wdata;
                  rwpsc_pkg::PHY_CTRL_IDX: begin
                     next_s.phy_ctrl = link.req_wdata[15:0];
                     if (link.req_wdata[rwpsc_pkg::PHY_RST_BIT]) begin
                        next_s.phy_rst = 1'b1;
                        next_s.phy_cnt = rwpsc_pkg::PHY_RST_CYCLES;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end

      // Transceiver reset: own registers to defaults, bit reads one till done
      if (s.phy_rst) begin
         next_s.phy_ctrl = rwpsc_pkg::PHY_CTRL_RST;
         next_s.phy_ctrl[rwpsc_pkg::PHY_RST_BIT] = 1'b1;
         next_s.phy_cnt = s.phy_cnt - 4'h1;
         if (s.phy_cnt == 4'h1) begin
            next_s.phy_rst = 1'b0;
            next_s.phy_ctrl = rwpsc_pkg::PHY_CTRL_RST;
         end
      end

      // Wake pattern scan runs in every power state
      if (rx_valid) begin
         if (rx_sof) begin
            next_s.ff_cnt = 3'h0;
            next_s.in_match = 1'b0;
            next_s.found = 1'b0;
         end
         if (s.in_match && !rx_sof) begin
            if (rx_data == mac_byte) begin
               hit = 1'b1;
               next_s.byte_idx = s.byte_idx + 3'h1;
               if (s.byte_idx == rwpsc_pkg::MAC_LAST_BYTE) begin
                  next_s.byte_idx = 3'h0;
                  next_s.rep = s.rep + 4'h1;
                  if (s.rep == rwpsc_pkg::WAKE_LAST_REP) begin
                     next_s.in_match = 1'b0;
                     next_s.found = 1'b1;
                     done_now = 1'b1;
                     next_s.ff_cnt = 3'h0;
                  end
               end
            end else begin
               next_s.in_match = 1'b0;
               next_s.ff_cnt = (rx_data == rwpsc_pkg::WAKE_SYNC_BYTE) ? 3'h1 : 3'h0;
            end
         end else if (rx_data == rwpsc_pkg::WAKE_SYNC_BYTE) begin
            if (rx_sof || s.ff_cnt != rwpsc_pkg::WAKE_FF_MIN) begin
               next_s.ff_cnt = (rx_sof ? 3'h0 : s.ff_cnt) + 3'h1;
            end
         end else begin
            next_s.ff_cnt = 3'h0;
            // A first address byte of FF is taken as part of the run
            if (!rx_sof && s.ff_cnt == rwpsc_pkg::WAKE_FF_MIN && rx_data == mac_byte) begin
               next_s.in_match = 1'b1;
               next_s.byte_idx = 3'h1;
               next_s.rep = 4'h0;
            end
         end
         if (!s.in_match || rx_sof || !hit) begin
            if (!(s.in_match && !rx_sof) && !(next_s.in_match)) begin
               next_s.byte_idx = 3'h0;
            end
         end
         if (rx_eof) begin
            if ((s.found && !rx_sof || done_now) && rx_addr_ok && rx_crc_ok
                && s.cfg18[rwpsc_pkg::WAKE_EN_BIT]) begin
               next_s.pme_stat = 1'b1;
               next_s.wake = 1'b1;
            end
            next_s.ff_cnt = 3'h0;
            next_s.in_match = 1'b0;
            next_s.found = 1'b0;
         end
      end

      // Internal reset countdown, then recall from EEPROM
      if (s.in_reset) begin
         next_s.rst_cnt = s.rst_cnt - 4'h1;
         if (s.rst_cnt == 4'h1) begin
            next_s.in_reset = 1'b0;
            next_s.bus_mode[rwpsc_pkg::SOFT_RST_BIT] = 1'b0;
            next_s.loading = 1'b1;
         end
      end
      if (s.loading && ee_valid) begin
         next_s.cfg18[31:rwpsc_pkg::RECALL_LSB] = ee_data;
         next_s.loading = 1'b0;
      end

      // Every reset except the transceiver reset drops the wake request too
      if (do_reset || !link.pci_rst_n) begin
         next_s = DEV_RST;
         next_s.bus_mode[rwpsc_pkg::SOFT_RST_BIT] = do_reset;
         next_s.ack = take;
         next_s.rdata = rd_word;
      end

      next_s.pme_oe_n = !next_s.pme_stat;
      next_s.mac_en = (next_s.pstate == rwpsc_pkg::PS_D0) && !next_s.in_reset && !next_s.loading;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= DEV_RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign link.ack = s.ack;
   assign link.rdata = s.rdata;
   assign link.pme_o = s.pme_o;
   assign link.pme_oe_n = s.pme_oe_n;
   assign ee_load_req = s.loading;
   assign ee_addr = s.ee_addr;
   assign mac_enable = s.mac_en;
   assign chip_reset = s.in_reset;
   assign phy_reset = s.phy_rst;
   assign wake_event = s.wake;
   assign power_state = s.pstate;

endmodule

// [hw/rwpsc_host.sv]
module rwpsc_host #(
   parameter int unsigned HRST_CYCLES = 32'(rwpsc_pkg::HRST_CYCLES)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   rwpsc_link_if.host link
);

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      RWPSC_IDLE = 3'b001,
      RWPSC_REQ = 3'b010,
      RWPSC_RST = 3'b100
   } rwpsc_hstate_t;

   typedef struct packed {
      rwpsc_hstate_t st;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [31:0] cnt;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic we;
      logic cfg;
      logic req;
      logic pci_rst_n;
      logic [1:0] bus_state;
      logic done;
      logic abort;
      logic pme_s1;
      logic pme_s2;
      logic reinit;
      logic [1:0] last_ps;
   } rwpsc_host_st_t;

   localparam rwpsc_host_st_t HOST_RST = '{
      st: RWPSC_IDLE,
      pci_rst_n: 1'b1,
      pme_s1: 1'b1,
      pme_s2: 1'b1,
      last_ps: rwpsc_pkg::PS_D0,
      default: '0
   };

   rwpsc_host_st_t s;
   rwpsc_host_st_t next_s;
   logic [31:0] status;
   logic wr;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      status = 32'h0000_0000;
      status[rwpsc_pkg::S_BUSY] = (s.st == RWPSC_REQ);
      status[rwpsc_pkg::S_DONE] = s.done;
      status[rwpsc_pkg::S_ABORT] = s.abort;
      status[rwpsc_pkg::S_PME] = !s.pme_s2;
      status[rwpsc_pkg::S_RST] = (s.st == RWPSC_RST);
      status[rwpsc_pkg::S_REINIT] = s.reinit;
      mapped = (paddr == rwpsc_pkg::H_CTRL) || (paddr == rwpsc_pkg::H_ADDR) || (paddr == rwpsc_pkg::H_WDATA)
               || (paddr == rwpsc_pkg::H_RDATA) || (paddr == rwpsc_pkg::H_STATUS);

      // Wake pin is asynchronous to software, so two stages
      next_s.pme_s1 = link.pme_n;
      next_s.pme_s2 = s.pme_s1;

      // One wait state keeps every APB output registered
      next_s.pready = psel && penable && !s.pready;
      next_s.pslverr = psel && penable && !s.pready && !mapped;
      next_s.prdata = 32'h0000_0000;
      if (psel && penable && !s.pready) begin
         unique case (paddr)
            rwpsc_pkg::H_CTRL: next_s.prdata = {22'h0, s.bus_state, 8'h00};
            rwpsc_pkg::H_ADDR: next_s.prdata = {24'h0, s.addr};
            rwpsc_pkg::H_WDATA: next_s.prdata = s.wdata;
            rwpsc_pkg::H_RDATA: next_s.prdata = s.rdata;
            rwpsc_pkg::H_STATUS: next_s.prdata = status;
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end

      wr = psel && penable && s.pready && pwrite;
      if (wr) begin
         unique case (paddr)
            rwpsc_pkg::H_ADDR: next_s.addr = pwdata[7:0];
            rwpsc_pkg::H_WDATA: next_s.wdata = pwdata;
            rwpsc_pkg::H_STATUS: begin
               if (pwdata[rwpsc_pkg::S_REINIT]) begin
                  next_s.reinit = 1'b0;
               end
            end
            rwpsc_pkg::H_CTRL: begin
               next_s.bus_state = pwdata[rwpsc_pkg::C_BS_LSB +: 2];
               // Commands while busy are dropped
               if (s.st == RWPSC_IDLE && pwdata[rwpsc_pkg::C_HRST]) begin
                  next_s.st = RWPSC_RST;
                  next_s.pci_rst_n = 1'b0;
                  next_s.cnt = HRST_CYCLES - 32'd1;
                  next_s.last_ps = rwpsc_pkg::PS_D0;
               end else if (s.st == RWPSC_IDLE && pwdata[rwpsc_pkg::C_GO]) begin
                  next_s.st = RWPSC_REQ;
                  next_s.req = 1'b1;
                  next_s.we = pwdata[rwpsc_pkg::C_WRITE];
                  next_s.cfg = pwdata[rwpsc_pkg::C_CFG];
                  next_s.done = 1'b0;
                  next_s.abort = 1'b0;
                  next_s.cnt = {27'h0, rwpsc_pkg::TIMEOUT_CYCLES};
               end
            end
            default: ;
         endcase
      end

      unique case (s.st)
         RWPSC_IDLE: ;
         RWPSC_REQ: begin
            if (link.ack) begin
               next_s.req = 1'b0;
               next_s.rdata = link.rdata;
               next_s.done = 1'b1;
               next_s.st = RWPSC_IDLE;
               if (s.we && s.cfg && s.addr == rwpsc_pkg::PM_IDX) begin
                  next_s.last_ps = s.wdata[rwpsc_pkg::PSTATE_LSB +: 2];
                  if (s.last_ps == rwpsc_pkg::PS_D3 && s.wdata[rwpsc_pkg::PSTATE_LSB +: 2] == rwpsc_pkg::PS_D0) begin
                     next_s.reinit = 1'b1;
                  end
               end
            end else if (s.cnt == 32'd0) begin
               // Ignored access ends as a master abort
               next_s.req = 1'b0;
               next_s.abort = 1'b1;
               next_s.st = RWPSC_IDLE;
            end else begin
               next_s.cnt = s.cnt - 32'd1;
            end
         end
         RWPSC_RST: begin
            next_s.cnt = s.cnt - 32'd1;
            if (s.cnt == 32'd0) begin
               next_s.pci_rst_n = 1'b1;
               next_s.st = RWPSC_IDLE;
            end
         end
      endcase
   end

   // Clock is fixed well above the 16 MHz floor of normal operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= HOST_RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign link.pci_rst_n = s.pci_rst_n;
   assign link.bus_state = s.bus_state;
   assign link.req = s.req;
   assign link.req_cfg = s.cfg;
   assign link.req_we = s.we;
   assign link.req_addr = s.addr;
   assign link.req_wdata = s.wdata;

endmodule

// [verif/rwpsc_assertions.sv]
module rwpsc_assertions #(
   parameter int unsigned HRST_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pci_rst_n,
   input wire logic [1:0] bus_state,
   input wire logic req,
   input wire logic req_cfg,
   input wire logic req_we,
   input wire logic [7:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic ack,
   input wire logic pme_o,
   input wire logic pme_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // Shadow of the power state, since the link itself never shows it
   logic [1:0] pstate_q;
   logic [3:0] quiet_q;
   int unsigned low_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate_q <= rwpsc_pkg::PS_D0;
         quiet_q <= 4'h0;
         low_q <= 0;
      end else begin
         if (!pci_rst_n) begin
            pstate_q <= rwpsc_pkg::PS_D0;
         end else if (ack && req_we && req_cfg && req_addr == rwpsc_pkg::PM_IDX) begin
            pstate_q <= req_wdata[1:0];
         end else if (ack && req_we && !req_cfg && req_addr == rwpsc_pkg::BUS_MODE_IDX && req_wdata[0]) begin
            pstate_q <= rwpsc_pkg::PS_D0;
         end
         // Cleared while a write is pending, so a release at the ack edge is covered
         quiet_q <= (!pci_rst_n || (req && req_we)) ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
         low_q <= pci_rst_n ? 0 : low_q + 1;
      end
   end
   ////////////////////////////////////////
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_after_req: assert property ($rose(ack) |-> $past(req))
      else $error("ack without request");
   a_io_only_d0: assert property (ack && !req_cfg |-> pstate_q == rwpsc_pkg::PS_D0)
      else $error("register access answered in low power");
   a_cfg_bus_gate: assert property (ack && req_cfg && pstate_q[1] |-> $past(bus_state) <= rwpsc_pkg::BS_B1)
      else $error("config answered in D2 or D3 outside B0 or B1");
   a_pme_drive_low: assert property (!pme_oe_n |-> !pme_o)
      else $error("wake request not driven low");
   a_pme_holds: assert property ($rose(pme_oe_n) |-> quiet_q < 4'hC)
      else $error("wake request dropped without clear or reset");
   a_pme_reset_release: assert property (!pci_rst_n |=> pme_oe_n && !ack)
      else $error("activity during PCI reset");
   a_req_drop: assert property ($rose(req) |-> ##[1:18] !req)
      else $error("request neither answered nor aborted");
   a_hrst_length: assert property ($rose(pci_rst_n) |-> low_q >= HRST_CYCLES - 1)
      else $error("PCI reset pulse too short");
endmodule

// [verif/test_reset_wake_power_state_ctrl.sv]
module test_reset_wake_power_state_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned HRST = 20;
   localparam logic [47:0] MAC = 48'h0A1B_2C3D_4E5F;
   localparam logic [31:0] RECALL = 32'h0004_0000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic rx_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0, rx_addr_ok = 1'b0, rx_crc_ok = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic ee_valid = 1'b0, ee_load_req, mac_enable, chip_reset, phy_reset, wake_event;
   logic [6:0] ee_addr;
   logic [1:0] power_state, bs = 2'h0;
   // Event counters; only the sampling process drives them
   int unsigned rst_seen = 0, phy_seen = 0, wake_seen = 0;
   int errors = 0, tests_run = 0;
   rwpsc_link_if link (.pclk(pclk));
   rwpsc_host #(.HRST_CYCLES(HRST)) u_rwpsc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link));
   rwpsc_dev u_rwpsc_dev (.pclk(pclk), .presetn(presetn), .link(link), .station_addr(MAC), .rx_valid(rx_valid),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .rx_addr_ok(rx_addr_ok), .rx_crc_ok(rx_crc_ok),
      .ee_valid(ee_valid), .ee_data(RECALL[31:16]), .ee_load_req(ee_load_req), .ee_addr(ee_addr),
      .mac_enable(mac_enable), .chip_reset(chip_reset), .phy_reset(phy_reset), .wake_event(wake_event),
      .power_state(power_state));
   rwpsc_assertions #(.HRST_CYCLES(HRST)) u_rwpsc_assertions (.pclk(pclk), .presetn(presetn),
      .pci_rst_n(link.pci_rst_n), .bus_state(link.bus_state), .req(link.req), .req_cfg(link.req_cfg),
      .req_we(link.req_we), .req_addr(link.req_addr), .req_wdata(link.req_wdata), .ack(link.ack),
      .pme_o(link.pme_o), .pme_oe_n(link.pme_oe_n));
   ////////////////////////////////////////
   always #12.5 pclk = ~pclk;
   // EEPROM answers one word per load request
   always @(posedge pclk) begin
      ee_valid <= ee_load_req && !ee_valid;
      if (chip_reset) rst_seen <= rst_seen + 1;
      if (phy_reset) phy_seen <= phy_seen + 1;
      if (wake_event) wake_seen <= wake_seen + 1;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic lnk(input logic we, cfg, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
         output logic ab);
      logic [31:0] s;
      apb(1'b1, rwpsc_pkg::H_ADDR, {24'h0, idx}, s);
      apb(1'b1, rwpsc_pkg::H_WDATA, wd, s);
      apb(1'b1, rwpsc_pkg::H_CTRL, {22'h0, bs, 5'h00, cfg, we, 1'b1}, s);
      do apb(1'b0, rwpsc_pkg::H_STATUS, 32'h0, s); while (s[rwpsc_pkg::S_BUSY] !== 1'b0);
      ab = s[rwpsc_pkg::S_ABORT];
      apb(1'b0, rwpsc_pkg::H_RDATA, 32'h0, rd);
   endtask
   // Back in D0 with loading done; a gap between reset and load cannot fool this
   task automatic idle;
      do @(posedge pclk); while (mac_enable !== 1'b1 || phy_reset !== 1'b0);
   endtask
   task automatic frame(input int nff, input logic aok, cok);
      logic [7:0] b[$];
      for (int i = 0; i < 6; i++) b.push_back(MAC[47 - 8 * i -: 8]);
      repeat (nff) b.push_back(8'hFF);
      for (int i = 0; i < 96; i++) b.push_back(MAC[47 - 8 * (i % 6) -: 8]);
      b.push_back(8'h00);
      foreach (b[i]) begin
         @(posedge pclk);
         rx_valid <= 1'b1;
         rx_sof <= (i == 0);
         rx_eof <= (i == b.size() - 1);
         rx_data <= b[i];
         rx_addr_ok <= aok;
         rx_crc_ok <= cok;
      end
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_eof <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   ////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic a;
      int unsigned n_rst, n_phy, n_wake;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      do @(posedge pclk); while (ee_load_req !== 1'b1);
      check(ee_addr, rwpsc_pkg::EE_RECALL_OFS);
      idle();
      apb(1'b0, 8'h20, 32'h0, r);
      check(err, 1'b1);
      // Soft reset restores what software changed
      lnk(1'b1, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      lnk(1'b0, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      check(r, 32'h0);
      n_rst = rst_seen;
      lnk(1'b1, 1'b0, rwpsc_pkg::BUS_MODE_IDX, 32'h1, r, a);
      idle();
      check(rst_seen != n_rst, 1'b1);
      lnk(1'b0, 1'b0, rwpsc_pkg::BUS_MODE_IDX, 32'h0, r, a);
      check(r, 32'h0);
      lnk(1'b0, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      check(r, RECALL);
      // Low power: D1 then D3hot with gated bus states
      lnk(1'b1, 1'b1, rwpsc_pkg::PM_IDX, 32'h1, r, a);
      check(power_state, rwpsc_pkg::PS_D1);
      check(mac_enable, 1'b0);
      lnk(1'b0, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      check(a, 1'b1);
      lnk(1'b1, 1'b1, rwpsc_pkg::PM_IDX, 32'h3, r, a);
      bs = 2'h2;
      lnk(1'b0, 1'b1, rwpsc_pkg::PM_IDX, 32'h0, r, a);
      check(a, 1'b1);
      bs = 2'h1;
      lnk(1'b0, 1'b1, rwpsc_pkg::PM_IDX, 32'h0, r, a);
      check({a, r[1:0]}, 3'b011);
      frame(6, 1'b1, 1'b1);
      check(link.pme_n, 1'b0);
      n_rst = rst_seen;
      lnk(1'b1, 1'b1, rwpsc_pkg::PM_IDX, 32'h0, r, a);
      idle();
      check({rst_seen != n_rst, link.pme_n, power_state}, 4'hC);
      // Host must flag the full re-initialisation, cleared by writing one
      apb(1'b0, rwpsc_pkg::H_STATUS, 32'h0, r);
      check(r[rwpsc_pkg::S_REINIT], 1'b1);
      apb(1'b1, rwpsc_pkg::H_STATUS, 32'h20, r);
      apb(1'b0, rwpsc_pkg::H_STATUS, 32'h0, r);
      check(r[rwpsc_pkg::S_REINIT], 1'b0);
      bs = 2'h0;
      // Only the whole pattern with good address and CRC wakes
      for (int k = 0; k < 4; k++) begin
         n_wake = wake_seen;
         frame(k == 1 ? 5 : 6, k != 2, k != 3);
         check({wake_seen != n_wake, link.pme_n}, {k == 0, k != 0});
         apb(1'b0, rwpsc_pkg::H_STATUS, 32'h0, r);
         check(r[rwpsc_pkg::S_PME], k == 0);
         lnk(1'b0, 1'b1, rwpsc_pkg::PM_IDX, 32'h0, r, a);
         check(r[rwpsc_pkg::PME_STAT_BIT], k == 0);
         repeat (20) @(posedge pclk);
         check(link.pme_n, k != 0);
         lnk(1'b1, 1'b1, rwpsc_pkg::PM_IDX, 32'h8000, r, a);
         check(link.pme_n, 1'b1);
      end
      lnk(1'b1, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      frame(6, 1'b1, 1'b1);
      check(link.pme_n, 1'b1);
      // Transceiver reset leaves the rest alone
      {n_phy, n_rst} = {phy_seen, rst_seen};
      lnk(1'b1, 1'b0, rwpsc_pkg::PHY_CTRL_IDX, 32'h8000, r, a);
      idle();
      check({phy_seen != n_phy, rst_seen != n_rst}, 2'b10);
      lnk(1'b0, 1'b0, rwpsc_pkg::PHY_CTRL_IDX, 32'h0, r, a);
      check(r, 32'h0);
      // PCI reset from the host brings defaults back
      n_rst = rst_seen;
      apb(1'b1, rwpsc_pkg::H_CTRL, 32'h8, r);
      do apb(1'b0, rwpsc_pkg::H_STATUS, 32'h0, r); while (r[rwpsc_pkg::S_RST] !== 1'b0);
      idle();
      lnk(1'b0, 1'b0, rwpsc_pkg::CFG18_IDX, 32'h0, r, a);
      check({rst_seen != n_rst, r}, {1'b1, RECALL});
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      stop_test();
   end
endmodule
